// >>> bench/gputc_ext_model.sv
// external clock source facing the timer
`default_nettype none
module gputc_ext_model(input wire logic clk_sys, run, input wire logic [1:0] half, output var logic ext_clk);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt = 2'h0;
   initial ext_clk = 1'h0;
   // half of 2 or more keeps the clock under 20 MHz; stands low when not run
   always @(posedge clk_sys) begin
      cnt <= (cnt >= half) ? 2'h0 : cnt + 2'h1;
      if (cnt >= half)
         ext_clk <= run & ~ext_clk;
   end
endmodule // gputc_ext_model
`default_nettype wire

// >>> bench/gputc_timer_assertions.sv
// port assertions for the up/down timer/counter
`default_nettype none
module gputc_timer_assertions(input wire logic clk_sys, rst_n, load_stb, mode_sel, clk_src_sel, gate_src_sel,
   dir_src_sel, dir_soft, count_en, ext_clk, ext_gate, ext_dir, tc_out, input wire logic [15:0] load_value, count_value);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence hold_s; ##1 $stable(count_value) && $stable(tc_out); endsequence
   a_load_takes: assert property (load_stb |=> count_value == $past(load_value) && !tc_out) else $error("load");
   a_soft_hold: assert property (!count_en && !load_stb |-> hold_s) else $error("soft gate");
   a_gate_hold: assert property (gate_src_sel && !ext_gate && !load_stb |-> hold_s) else $error("gate");
   a_no_edge: assert property (clk_src_sel && !load_stb && !(ext_clk && !$past(ext_clk)) |-> hold_s) else $error("edge");
   a_step_down: assert property (!$past(load_stb) && !$past(mode_sel) && !$past(dir_src_sel) && !$past(dir_soft)
      && $changed(count_value) |-> count_value == $past(count_value) - 16'h1) else $error("down");
   a_step_up: assert property (!$past(load_stb) && !$past(mode_sel) && $past(dir_src_sel) && $past(ext_dir)
      && $changed(count_value) |-> count_value == $past(count_value) + 16'h1) else $error("up");
   a_tc_zero: assert property ($rose(tc_out) && !mode_sel |-> count_value == 16'h0) else $error("tc");
   a_tc_stays: assert property (tc_out && !mode_sel && !load_stb |-> hold_s) else $error("tc hold");
   a_pulse_one: assert property ($rose(tc_out) && mode_sel |-> count_value == 16'h1) else $error("pulse");
endmodule // gputc_timer_assertions
bind gputc_timer gputc_timer_assertions chk_u(.*);
`default_nettype wire

// >>> bench/gputc_timer_bench.sv
// self-checking bench for the up/down timer/counter
`default_nettype none
module gputc_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, rst_n = 0, load_stb = 0, mode_sel = 0, clk_src_sel = 1, gate_src_sel = 0, dir_src_sel = 0;
   logic dir_soft = 0, count_en = 1, ext_gate = 1, ext_dir = 0, run = 1, ext_clk, tc_out;
   logic [1:0] half = 2'h2;
   logic [15:0] load_value = 16'h0, count_value;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   gputc_timer dut_u(.*);
   gputc_ext_model ext_u(.*);
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cyc > 3000) begin
      n_mismatch++;
      stop_test();
   end
   task chk(input logic [16:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task load(input logic [15:0] v);
      @(negedge clk_sys);
      load_stb = 1'h1;
      load_value = v;
      @(negedge clk_sys);
      load_stb = 1'h0;
      chk({count_value, tc_out}, {v, 1'h0});
   endtask
   task wtc(input logic v);
      for (int k = 0; k < 200 && tc_out !== v; k++) @(negedge clk_sys);
   endtask
   task t_mode0;
      load(16'h3);
      wtc(1'h1);
      repeat (20) @(negedge clk_sys);
      chk({count_value, tc_out}, {16'h0, 1'h1});
      $display("t_mode0 end");
   endtask
   task t_rate;
      mode_sel = 1'h1;
      dir_src_sel = 1'h1;
      half = 2'h3;
      load(16'h3);
      wtc(1'h1);
      chk(count_value, 16'h1);
      wtc(1'h0);
      chk(count_value, 16'h3);
      $display("t_rate end");
   endtask
   task t_gate;
      mode_sel = 1'h0;
      ext_dir = 1'h1;
      gate_src_sel = 1'h1;
      ext_gate = 1'h0;
      load(16'h5);
      repeat (40) @(negedge clk_sys);
      chk(count_value, 16'h5);
      {ext_gate, count_en, gate_src_sel, clk_src_sel} = 4'h8;
      repeat (40) @(negedge clk_sys);
      chk(count_value, 16'h5);
      count_en = 1'h1;
      repeat (40) @(negedge clk_sys);
      chk(count_value > 16'h5, 1'h1);
      $display("t_gate end");
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      rst_n = 1'h1;
      t_mode0;
      t_rate;
      t_gate;
      stop_test;
   end
endmodule // gputc_timer_bench
`default_nettype wire

// >>> design/gputc_timer.v
// general-purpose 16-bit up/down timer/counter with two output modes
`default_nettype none
`include "gputc_defines.vh"

// Summary of operation
// (RULE1) one independent sixteen-bit counter that counts up or down
// (RULE2) direction from hardware pin or software bit; low/0 down, high/1 up
// (RULE3) count clock is internal 24 MHz timebase or external clock up to 20 MHz
// (RULE4) internal gating: only the software enable stops counting
// (RULE5) external gating: software disable or low gate pin stops counting
// (RULE6) software can write an initial count
// (RULE7) present count readable any time without disturbing operation
// (RULE8) mode 0: load drives output low; high at zero until next load
// (RULE9) mode 1: output low after load; one-tick high pulse at count of one
// (RULE10) mode 1: after the pulse the initial count reloads and repeats
// (RULE11) software must load an initial count above one in mode 1
// (RULE12) while gated off, count and output hold their values
module gputc_timer (
   input  wire        clk_sys,
   input  wire        rst_n,
   input  wire        load_stb,
   input  wire [15:0] load_value,
   input  wire        mode_sel,
   input  wire        clk_src_sel,
   input  wire        gate_src_sel,
   input  wire        dir_src_sel,
   input  wire        dir_soft,
   input  wire        count_en,
   input  wire        ext_clk,
   input  wire        ext_gate,
   input  wire        ext_dir,
   output reg  [15:0] count_value,
   output reg         tc_out
);

   reg [15:0] count_reg;
   reg [15:0] count_next;
   reg [15:0] init_reg;
   reg        out_reg;
   reg        out_next;
   reg        armed_reg;
   reg        armed_next;
   reg        ext_clk_d_reg;
   reg [26:0] tb_acc_reg;
   reg [26:0] tb_sum;
   reg        tb_tick;
   reg        tick;
   reg        enabled;
   reg        up;

   // fractional accumulator: 24 MHz ticks from the 100 MHz clock, no drift
   always @* begin
      tb_sum = tb_acc_reg + 27'd24000000;
      tb_tick = 1'b0;
      if (tb_sum >= 27'd100000000) begin
         tb_sum = tb_sum - 27'd100000000;
         tb_tick = 1'b1;
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         tb_acc_reg    <= 27'h0000000;
         ext_clk_d_reg <= 1'b0;
      end else begin
         tb_acc_reg    <= tb_sum;
         ext_clk_d_reg <= ext_clk;
      end
   end

   // external clock sampled as a synchronous input; rising edge counts
   always @* begin
      if (clk_src_sel == `GPUTC_CLK_EXTERNAL)
         tick = ext_clk & ~ext_clk_d_reg; // RULE3
      else
         tick = tb_tick; // RULE3
      if (gate_src_sel == `GPUTC_GATE_EXT)
         enabled = count_en & ext_gate; // RULE5
      else
         enabled = count_en; // RULE4
      if (dir_src_sel == `GPUTC_DIR_HW)
         up = ext_dir; // RULE2
      else
         up = dir_soft; // RULE2
   end

   always @* begin
      count_next = count_reg;
      out_next   = out_reg;
      armed_next = armed_reg;
      if (load_stb) begin
         count_next = load_value; // RULE6
         out_next   = 1'b0; // RULE8
         armed_next = 1'b1;
      end else if (tick && enabled && armed_reg) begin // RULE12
         if (mode_sel == `GPUTC_MODE_RATE) begin
            if (out_reg) begin
               count_next = init_reg; // RULE10
               out_next   = 1'b0; // RULE9
            end else begin
               if (up)
                  count_next = count_reg + 16'h0001; // RULE1
               else
                  count_next = count_reg - 16'h0001; // RULE1
               if (count_next == 16'h0001)
                  out_next = 1'b1; // RULE9
            end
         end else if (!out_reg) begin
            if (up)
               count_next = count_reg + 16'h0001; // RULE1
            else
               count_next = count_reg - 16'h0001; // RULE1
            if (count_next == 16'h0000)
               out_next = 1'b1; // RULE8
         end
      end
   end

   // output held high in mode 0 until reload; count stops there too
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         count_reg   <= `GPUTC_RST_COUNT;
         init_reg    <= `GPUTC_RST_LOAD;
         out_reg     <= 1'b0;
         armed_reg   <= 1'b0;
         count_value <= `GPUTC_RST_COUNT;
         tc_out      <= 1'b0;
      end else begin
         count_reg   <= count_next;
         out_reg     <= out_next;
         armed_reg   <= armed_next;
         count_value <= count_next; // RULE7
         tc_out      <= out_next;
         if (load_stb)
            init_reg <= load_value; // RULE10
      end
   end

endmodule // gputc_timer
`default_nettype wire

// >>> include/gputc_defines.vh
// constants for the general-purpose up/down timer/counter
`ifndef GPUTC_DEFINES_VH
`define GPUTC_DEFINES_VH
`define GPUTC_WIDTH        16
`define GPUTC_MODE_TC      1'b0
`define GPUTC_MODE_RATE    1'b1
`define GPUTC_CLK_INTERNAL 1'b0
`define GPUTC_CLK_EXTERNAL 1'b1
`define GPUTC_GATE_INT     1'b0
`define GPUTC_GATE_EXT     1'b1
`define GPUTC_DIR_SOFT     1'b0
`define GPUTC_DIR_HW       1'b1
`define GPUTC_RST_COUNT    16'h0000
`define GPUTC_RST_LOAD     16'h0000
`define GPUTC_TB_HZ        24000000
`define GPUTC_SYS_HZ       100000000
`define GPUTC_TB_ACC_W     27
`endif
